// *** secl_pkg.sv ***
// Purpose: shared constants for the serial eeprom config loader
// Assumes: pclk at 40 MHz, eeprom in 16-bit word organisation
// Notes: register offsets are apb byte addresses
package secl_pkg;

    // ----------------------------------------
    // bus types
    // ----------------------------------------
    typedef logic [11:0] secl_addr_t;
    typedef logic [31:0] secl_data_t;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam secl_addr_t SECL_A_LCW = 12'h000;
    localparam secl_addr_t SECL_A_STAT = 12'h004;
    localparam secl_addr_t SECL_A_IDENT = 12'h008;
    localparam logic [4:0] SECL_A_LCFG_PG = 5'h02; // 0x100..0x17f
    localparam logic [4:0] SECL_A_PCFG_PG = 5'h04; // 0x200..0x27f

    // ----------------------------------------
    // local control word fields
    // ----------------------------------------
    localparam int SECL_LCW_SK = 24;
    localparam int SECL_LCW_CS = 25;
    localparam int SECL_LCW_DI = 26;
    localparam int SECL_LCW_DO = 27;
    localparam int SECL_LCW_VALID = 28;
    localparam int SECL_LCW_RELOAD = 29;

    // ----------------------------------------
    // eeprom word fields and defaults
    // ----------------------------------------
    localparam int SECL_B_MORE = 15;
    localparam logic [2:0] SECL_OP_RD = 3'h6; // start bit and read opcode
    localparam logic [6:0] SECL_IDENT_LIM = 7'h04;
    localparam logic [127:0] SECL_LCFG_WMASK = 128'h0000_0000_0000_0000_0000_0000_0000_ffff;
    localparam logic [7:0] SECL_BYTE_RST = 8'h00;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int SECL_CLK_NS = 25;
    localparam int SECL_SK_HALF_NS = 500;
    localparam int SECL_SK_HALF_CYC = (SECL_SK_HALF_NS + SECL_CLK_NS - 1) / SECL_CLK_NS;

    // ----------------------------------------
    // loader states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SECL_ST_IDLE = 2'b00,
        SECL_ST_FETCH = 2'b01,
        SECL_ST_WAIT = 2'b10,
        SECL_ST_EXEC = 2'b11
    } secl_st_t;

    // writable bits of each pci config byte
    function automatic logic [7:0] secl_pcfg_wmask(input logic [6:0] off);
        case (off)
            7'h02, 7'h03, 7'h09, 7'h0a, 7'h0b: secl_pcfg_wmask = 8'hff;
            7'h2e, 7'h2f, 7'h3d, 7'h42, 7'h43: secl_pcfg_wmask = 8'hff;
            7'h06: secl_pcfg_wmask = 8'h10;
            default: secl_pcfg_wmask = 8'h00;
        endcase
    endfunction : secl_pcfg_wmask

endpackage : secl_pkg

// *** secl_ser_if.sv ***
// Purpose: word read request between loader and serial engine
// Assumes: one request at a time
// Notes: pin levels travel here as well
interface secl_ser_if #(parameter int AW = 6);
    logic start;
    logic [AW-1:0] addr;
    logic busy;
    logic done;
    logic absent;
    logic [15:0] data;
    logic sk;
    logic cs;
    logic di;
    logic dout_s;

    modport ctrl(output start, addr, dout_s, input busy, done, absent, data, sk, cs, di);
    modport eng(input start, addr, dout_s, output busy, done, absent, data, sk, cs, di);
endinterface : secl_ser_if

// *** secl_sync.sv ***
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: input is a level
// Notes: the first stage feeds only the second
module secl_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] q_q;

    // two stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q_q <= '0;
        end else begin
            meta_q <= d;
            q_q <= meta_q;
        end
    end

    assign q = q_q;

endmodule : secl_sync

// *** secl_ser.sv ***
// Purpose: serial eeprom word reader
// Assumes: eeprom samples data in on rising clock, drives data out after it
// Notes: a dummy bit that is not low means no eeprom is fitted
module secl_ser #(
    parameter int AW = 6,
    parameter int HALF = secl_pkg::SECL_SK_HALF_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request and pins
    secl_ser_if.eng ser
);
    import secl_pkg::*;

    localparam int NB = 3 + AW + 1 + 16;

    logic [15:0] half_q;
    logic [5:0] bit_q;
    logic [AW+2:0] cmd_q;
    logic [15:0] data_q;
    logic run_q, sk_q, cs_q, di_q, absent_q, done_q;

    // half period tick and bit phases
    wire tick = run_q && (half_q == 16'(HALF - 1));
    wire fall = tick && sk_q;
    wire is_dummy = bit_q == 6'(3 + AW);
    wire is_data = bit_q > 6'(3 + AW);
    wire is_last = bit_q == 6'(NB - 1);

    // command, address, then 16 data bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q <= '0;
            bit_q <= '0;
            cmd_q <= '0;
            data_q <= '0;
            run_q <= 1'b0;
            sk_q <= 1'b0;
            cs_q <= 1'b0;
            di_q <= 1'b0;
            absent_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!run_q) begin
                if (ser.start) begin
                    run_q <= 1'b1;
                    cs_q <= 1'b1;
                    cmd_q <= {SECL_OP_RD, ser.addr};
                    di_q <= SECL_OP_RD[2];
                    bit_q <= '0;
                    half_q <= '0;
                    absent_q <= 1'b0;
                end
            end else begin
                half_q <= tick ? '0 : half_q + 16'h0001;
                if (tick) begin
                    sk_q <= ~sk_q;
                end
                if (fall) begin
                    bit_q <= bit_q + 6'h01;
                    cmd_q <= {cmd_q[AW+1:0], 1'b0};
                    di_q <= cmd_q[AW+1];
                    if (is_dummy) begin
                        absent_q <= ser.dout_s; // floating line reads high
                    end
                    if (is_data) begin
                        data_q <= {data_q[14:0], ser.dout_s};
                    end
                    if (is_last) begin
                        run_q <= 1'b0;
                        cs_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
            end
        end
    end

    assign ser.sk = sk_q;
    assign ser.cs = cs_q;
    assign ser.di = di_q;
    assign ser.busy = run_q;
    assign ser.done = done_q;
    assign ser.absent = absent_q;
    assign ser.data = data_q;

endmodule : secl_ser

// *** secl_loader.sv ***
// Purpose: configuration loader from serial eeprom, apb register slave
// Assumes: pclk 40 MHz, presetn stands for the pci bus reset
// Notes: pci_retry is high for the whole download
//
// Operation
// - download starts at reset, ends absent/end
// - retry every host access while loading
// - no eeprom keeps default register values
// - four pins: clock, select, data out, in
// - read command, address, then 16-bit word
// - control bits 27:24 bit-bang eeprom pins
// - reload bit restarts download like reset
// - header signature match sets valid bit
// - header bits 3..0 flag zones 1..4
// - zones back to back, absent zones skipped
// - zone 1 writes byte at 7-bit offset
// - zone 1 end moves to next zone
// - only writable local registers change
// - zone 2 selectors 0..3 hit ident bytes
// - zone 2 bit 15 continues or moves on
// - zone 3 function header, only function 0
// - zone 3 words write selected function space
// - zone 3 word: offset, value, continue bit
// - zone 4 word pairs make function accesses
//
// Our own choices: the APB register port and the register addresses.
module secl_loader #(
    parameter int AW = 6,
    parameter logic [11:0] SIG = 12'h5a3, // arbitrary value
    parameter logic [15:0] VID_RST = 16'h1234, // arbitrary value
    parameter logic [15:0] SVID_RST = 16'h5678 // arbitrary value
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire secl_pkg::secl_addr_t paddr,
    input wire secl_pkg::secl_data_t pwdata,
    output secl_pkg::secl_data_t prdata,
    output logic pready,
    output logic pslverr,
    // eeprom pins
    output logic ee_sk,
    output logic ee_cs,
    output logic ee_di,
    input wire logic ee_do,
    // host retry
    output logic pci_retry,
    // function access
    output logic func_valid,
    output logic func_write,
    output logic [2:0] func_bar,
    output logic [7:0] func_addr,
    output logic [7:0] func_data
);
    import secl_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------

    secl_st_t st_q;
    logic [AW-1:0] addr_q;
    logic [2:0] zone_q;
    logic [3:0] flags_q;
    logic [15:0] word_q;
    logic absent_q;
    logic valid_q;
    logic z3data_q;
    logic fn_ok_q;
    logic z4sec_q;
    logic [15:0] w1_q;
    logic [2:0] bb_q; // sk, cs, di under software
    logic [7:0] lcfg_q [0:127];
    logic [7:0] pcfg_q [0:127];
    logic [7:0] ident_q [0:3];
    secl_data_t rd_q;
    logic fv_q, fw_q;
    logic [2:0] fb_q;
    logic [7:0] fa_q, fd_q;
    logic do_s;

    secl_ser_if #(.AW(AW)) ser();

    // ----------------------------------------
    // serial engine and pin input
    // ----------------------------------------

    // eeprom data in crosses into pclk
    secl_sync #(.W(1)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(ee_do),
        .q(do_s)
    );

    secl_ser #(.AW(AW)) u_ser (
        .pclk(pclk),
        .presetn(presetn),
        .ser(ser)
    );

    assign ser.dout_s = do_s;
    assign ser.addr = addr_q;
    assign ser.start = st_q == SECL_ST_FETCH;

    // ----------------------------------------
    // next present zone
    // ----------------------------------------

    // lowest present zone above cur, zero when none
    function automatic logic [2:0] next_zone(input logic [2:0] cur, input logic [3:0] fl);
        logic [2:0] r;
        r = 3'h0;
        for (int n = 4; n >= 1; n--) begin
            if (3'(n) > cur && fl[4-n]) begin
                r = 3'(n);
            end
        end
        return r;
    endfunction : next_zone

    // ----------------------------------------
    // word decode
    // ----------------------------------------

    // fields of the current word
    wire loading = st_q != SECL_ST_IDLE;
    wire exec = st_q == SECL_ST_EXEC;
    wire w_more = word_q[SECL_B_MORE];
    wire [6:0] w_off = word_q[14:8];
    wire [7:0] w_byte = word_q[7:0];
    wire in_z0 = zone_q == 3'h0;
    wire in_z1 = zone_q == 3'h1;
    wire in_z2 = zone_q == 3'h2;
    wire in_z3 = zone_q == 3'h3;
    wire in_z4 = zone_q == 3'h4;

    wire sig_ok = !absent_q && word_q[15:4] == SIG;
    wire hdr_bad = in_z0 && !sig_ok;
    // flags come from the header itself in zone 0
    wire [3:0] fl_use = in_z0 ? word_q[3:0] : flags_q;
    // next zone after the current one
    wire [2:0] nz = next_zone(zone_q, fl_use);

    wire cont = in_z0 ? 1'b0 : in_z3 ? (z3data_q | w_more) : in_z4 ? (~z4sec_q | w_more) : w_more;
    wire addr_end = addr_q == {AW{1'b1}};
    wire finish = hdr_bad || addr_end || (!cont && nz == 3'h0);

    wire lcfg_we = exec && in_z1 && SECL_LCFG_WMASK[w_off];
    // zone 2 ident write, reserved ignored
    wire ident_we = exec && in_z2 && w_off < SECL_IDENT_LIM;
    // zone 3 write only for a valid function
    wire pcfg_we = exec && in_z3 && z3data_q && fn_ok_q;
    wire [7:0] pmask = secl_pcfg_wmask(w_off);
    wire [7:0] pnew = (pcfg_q[w_off] & ~pmask) | (w_byte & pmask);
    // second word of a pair fires the access
    wire z4_fire = exec && in_z4 && z4sec_q;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_lcw = paddr == SECL_A_LCW;
    wire hit_stat = paddr == SECL_A_STAT;
    wire hit_ident = paddr == SECL_A_IDENT;
    wire hit_lcfg = paddr[11:7] == SECL_A_LCFG_PG;
    wire hit_pcfg = paddr[11:7] == SECL_A_PCFG_PG;
    wire hit_any = hit_lcw | hit_stat | hit_ident | hit_lcfg | hit_pcfg;
    wire [6:0] bidx = {paddr[6:2], 2'b00};
    wire apb_wr = access && pwrite && hit_lcw && !loading;
    wire reload = apb_wr && pwdata[SECL_LCW_RELOAD];

    // read data selection
    wire [31:0] lcw_rd = {2'b00, 1'b0, valid_q, do_s, bb_q[2], bb_q[1], bb_q[0], 24'h00_0000};
    wire [31:0] lcfg_rd = {lcfg_q[bidx + 7'h3], lcfg_q[bidx + 7'h2], lcfg_q[bidx + 7'h1], lcfg_q[bidx]};
    wire [31:0] pcfg_rd = {pcfg_q[bidx + 7'h3], pcfg_q[bidx + 7'h2], pcfg_q[bidx + 7'h1], pcfg_q[bidx]};
    wire [31:0] id_rd = {ident_q[3], ident_q[2], ident_q[1], ident_q[0]};
    wire [31:0] st_rd = {30'h0000_0000, absent_q, loading};
    wire [31:0] rd_mux = hit_lcw ? lcw_rd : hit_stat ? st_rd : hit_ident ? id_rd :
                         hit_lcfg ? lcfg_rd : hit_pcfg ? pcfg_rd : 32'h0000_0000;

    // ----------------------------------------
    // loader sequence
    // ----------------------------------------

    // reset starts the download at word 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= SECL_ST_FETCH;
            addr_q <= '0;
            zone_q <= 3'h0;
            word_q <= 16'h0000;
            absent_q <= 1'b0;
        end else begin
            unique case (st_q)
                SECL_ST_IDLE: begin
                    if (reload) begin
                        st_q <= SECL_ST_FETCH;
                        addr_q <= '0;
                        zone_q <= 3'h0;
                    end
                end
                SECL_ST_FETCH: begin
                    if (!ser.busy) begin
                        st_q <= SECL_ST_WAIT;
                    end
                end
                SECL_ST_WAIT: begin
                    if (ser.done) begin
                        word_q <= ser.data;
                        absent_q <= ser.absent;
                        st_q <= SECL_ST_EXEC;
                    end
                end
                SECL_ST_EXEC: begin
                    // end of program or next word
                    if (finish) begin
                        st_q <= SECL_ST_IDLE;
                    end else begin
                        st_q <= SECL_ST_FETCH;
                        addr_q <= addr_q + AW'(1);
                        if (!cont) begin
                            zone_q <= nz;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // header and zone sub-state
    // ----------------------------------------

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 4'h0;
            valid_q <= 1'b0;
        end else if (reload) begin
            flags_q <= 4'h0;
            valid_q <= 1'b0;
        end else if (exec && in_z0 && sig_ok) begin
            flags_q <= word_q[3:0];
            valid_q <= 1'b1;
        end
    end

    // function header selects function 0 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z3data_q <= 1'b0;
            fn_ok_q <= 1'b0;
        end else if (reload) begin
            z3data_q <= 1'b0;
            fn_ok_q <= 1'b0;
        end else if (exec && in_z3) begin
            if (!z3data_q && w_more) begin
                z3data_q <= 1'b1;
                fn_ok_q <= word_q[2:0] == 3'h0;
            end else if (z3data_q && !w_more) begin
                z3data_q <= 1'b0; // next word is a function header
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z4sec_q <= 1'b0;
            w1_q <= 16'h0000;
        end else if (reload) begin
            z4sec_q <= 1'b0;
        end else if (exec && in_z4) begin
            z4sec_q <= ~z4sec_q;
            if (!z4sec_q) begin
                w1_q <= word_q;
            end
        end
    end

    // function access strobe, read data discarded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fv_q <= 1'b0;
            fw_q <= 1'b0;
            fb_q <= 3'h0;
            fa_q <= 8'h00;
            fd_q <= 8'h00;
        end else begin
            fv_q <= z4_fire;
            if (z4_fire) begin
                fb_q <= w1_q[14:12];
                fw_q <= w1_q[11];
                fa_q <= w1_q[7:0];
                fd_q <= w_byte;
            end
        end
    end

    // ----------------------------------------
    // configuration storage
    // ----------------------------------------

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 128; i++) begin
                lcfg_q[i] <= SECL_BYTE_RST;
                pcfg_q[i] <= SECL_BYTE_RST;
            end
        end else if (reload) begin
            for (int i = 0; i < 128; i++) begin
                lcfg_q[i] <= SECL_BYTE_RST;
                pcfg_q[i] <= SECL_BYTE_RST;
            end
        end else begin
            if (lcfg_we) begin
                lcfg_q[w_off] <= w_byte;
            end
            // pci config byte, masked bits only
            if (pcfg_we) begin
                pcfg_q[w_off] <= pnew;
            end
        end
    end

    // ident bytes, vendor then subsystem vendor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ident_q[0] <= VID_RST[7:0];
            ident_q[1] <= VID_RST[15:8];
            ident_q[2] <= SVID_RST[7:0];
            ident_q[3] <= SVID_RST[15:8];
        end else if (reload) begin
            ident_q[0] <= VID_RST[7:0];
            ident_q[1] <= VID_RST[15:8];
            ident_q[2] <= SVID_RST[7:0];
            ident_q[3] <= SVID_RST[15:8];
        end else if (ident_we) begin
            ident_q[w_off[1:0]] <= w_byte;
        end
    end

    // ----------------------------------------
    // software pin control
    // ----------------------------------------

    // bit-bang levels from the control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bb_q <= 3'h0;
        end else if (apb_wr) begin
            bb_q <= {pwdata[SECL_LCW_DI], pwdata[SECL_LCW_CS], pwdata[SECL_LCW_SK]};
        end
    end

    assign ee_sk = loading ? ser.sk : bb_q[0];
    assign ee_cs = loading ? ser.cs : bb_q[1];
    assign ee_di = loading ? ser.di : bb_q[2];

    // ----------------------------------------
    // apb answer
    // ----------------------------------------

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= 32'h0000_0000;
        end else if (setup) begin
            rd_q <= rd_mux;
        end
    end

    // retry shown as error answer while loading
    assign pready = 1'b1;
    assign pslverr = access && (loading || !hit_any);
    assign prdata = rd_q;
    assign pci_retry = loading;

    // function access outputs
    assign func_valid = fv_q;
    assign func_write = fw_q;
    assign func_bar = fb_q;
    assign func_addr = fa_q;
    assign func_data = fd_q;

endmodule : secl_loader

// *** secl_eeprom_model.sv ***
// Purpose: behavioural word-organised serial eeprom
// Assumes: device drives clock and select, samples data out while clock is high
// Notes: an unfitted board reads data out high through its pull-up
module secl_eeprom_model #(
    parameter int AW = 6
) (
    // pins
    input wire logic ee_sk,
    input wire logic ee_cs,
    input wire logic ee_di,
    output logic ee_do,
    // board option
    input wire logic fitted
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:(1<<AW)-1];
    logic [AW+2:0] sh = '0;
    logic drv = 1'b0;
    logic val = 1'b0;
    int n = 0;
    // released line floats high through its pull-up
    assign ee_do = (fitted && drv) ? val : 1'b1;
    // restart the bit count whenever select drops
    always @(negedge ee_cs) begin
        n = 0;
        drv = 1'b0;
    end
    // command, address, dummy zero, data msb first
    always @(posedge ee_sk) begin
        if (ee_cs) begin
            n++;
            if (n <= AW + 3) begin
                sh = {sh[AW+1:0], ee_di};
            end else if (sh[AW+2:AW] == 3'b110) begin
                drv = 1'b1;
                val = (n == AW + 4) ? 1'b0 : mem[sh[AW-1:0]][AW+20-n];
            end
        end
    end
endmodule : secl_eeprom_model

// *** secl_loader_chk.sv ***
// Purpose: port checks for the config loader
// Assumes: one clock domain on pclk
// Notes: bound from the bench top file
module secl_loader_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // eeprom and status
    input wire logic ee_sk,
    input wire logic ee_cs,
    input wire logic ee_di,
    input wire logic pci_retry,
    input wire logic func_valid,
    input wire logic [7:0] func_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // one serial clock high phase of twenty cycles
    sequence sk_high_s;
        ##19 ee_sk ##1 !ee_sk;
    endsequence
    a_retry_slverr: assert property (psel && penable && pci_retry |-> pslverr)
        else $error("access not refused while loading");
    a_slverr_phase: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    a_ready_one: assert property (psel && penable |-> pready)
        else $error("no answer in access cycle");
    a_start_read: assert property ($rose(presetn) |-> ##[0:4] ee_cs)
        else $error("no read after reset");
    a_sk_high: assert property ($rose(ee_sk) && pci_retry |-> sk_high_s)
        else $error("serial clock phase wrong");
    a_sk_idle: assert property (pci_retry && !ee_cs |-> !ee_sk)
        else $error("serial clock without select");
    a_di_fall: assert property (pci_retry && ee_cs && $past(ee_cs) && !$fell(ee_sk) |-> $stable(ee_di))
        else $error("data out moved off clock fall");
    a_func_pulse: assert property (func_valid |=> !func_valid)
        else $error("access pulse too long");
    a_func_hold: assert property ($changed(func_addr) && !$changed(pci_retry) |-> func_valid)
        else $error("access address moved alone");
endmodule : secl_loader_chk

// *** secl_loader_tb.sv ***
// Purpose: self-checking bench for the config loader
// Assumes: model eeprom with six address bits
// Notes: expectations come from the words written to the model
module secl_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import secl_pkg::*;
    localparam logic [11:0] SIG = 12'h6c1; // arbitrary value
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fitted = 0, err;
    secl_addr_t paddr = '0;
    secl_data_t pwdata = '0, prdata, rd;
    logic pready, pslverr, ee_sk, ee_cs, ee_di, ee_do, pci_retry, func_valid, func_write;
    logic [2:0] func_bar;
    logic [7:0] func_addr, func_data;
    int failures = 0, checked = 0, nfunc = 0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (func_valid === 1'b1) nfunc <= nfunc + 1;
    secl_loader #(.SIG(SIG)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ee_sk(ee_sk), .ee_cs(ee_cs), .ee_di(ee_di), .ee_do(ee_do),
        .pci_retry(pci_retry), .func_valid(func_valid), .func_write(func_write),
        .func_bar(func_bar), .func_addr(func_addr), .func_data(func_data));
    secl_eeprom_model mdl (.ee_sk(ee_sk), .ee_cs(ee_cs), .ee_di(ee_di), .ee_do(ee_do), .fitted(fitted));
    task automatic end_sim();
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb_xfer(input logic wr, input secl_addr_t a, input secl_data_t wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer
    task automatic rchk(input secl_addr_t a, input secl_data_t exp, input secl_data_t m);
        apb_xfer(1'b0, a, '0);
        chk(rd & m, exp);
    endtask : rchk
    task automatic wait_load();
        repeat (3) @(posedge pclk);
        while (pci_retry !== 1'b0) @(posedge pclk);
    endtask : wait_load
    task automatic t_absent();
        apb_xfer(1'b0, SECL_A_STAT, '0);
        chk(err, 1);
        wait_load();
        rchk(SECL_A_STAT, 32'h0000_0002, '1);
        rchk(SECL_A_IDENT, 32'h5678_1234, '1);
        rchk(SECL_A_LCW, 32'h0800_0000, '1);
        rchk(12'h100, 32'h0000_0000, '1);
    endtask : t_absent
    task automatic t_program();
        logic [15:0] img [17] = '{{SIG, 4'hf}, 16'h83a5, 16'h2077, 16'h81be, 16'h8511, 16'h02cd,
            16'h8000, 16'hbd02, 16'h06ff, 16'h8001, 16'h3d99, 16'h0000, 16'h8010, 16'h8033,
            16'h9842, 16'h005a, 16'hffff};
        for (int i = 0; i < 17; i++) mdl.mem[i] = img[i];
        @(posedge pclk);
        presetn <= 1'b0;
        fitted <= 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb_xfer(1'b1, SECL_A_LCW, 32'h0700_0000);
        chk(err, 1);
        wait_load();
        rchk(SECL_A_STAT, 32'h0000_0000, '1);
        rchk(SECL_A_LCW, 32'h1000_0000, 32'h3700_0000);
        rchk(12'h100, 32'ha500_0000, '1);
        rchk(12'h120, 32'h0000_0000, '1);
        rchk(SECL_A_IDENT, 32'h56cd_be34, '1);
        rchk(12'h23c, 32'h0000_0200, '1);
        rchk(12'h204, 32'h0010_0000, '1);
        chk({func_write, func_bar, func_addr, func_data}, {1'b1, 3'd1, 8'h42, 8'h5a});
        chk(nfunc, 2);
    endtask : t_program
    task automatic t_badsig();
        mdl.mem[0] = {SIG ^ 12'h001, 4'hf};
        apb_xfer(1'b1, SECL_A_LCW, 32'h2000_0000);
        wait_load();
        rchk(SECL_A_LCW, 32'h0000_0000, 32'h1000_0000);
        rchk(SECL_A_IDENT, 32'h5678_1234, '1);
        rchk(12'h100, 32'h0000_0000, '1);
    endtask : t_badsig
    task automatic t_skip();
        mdl.mem[0] = {SIG, 4'h5};
        mdl.mem[1] = 16'h00ee;
        mdl.mem[2] = 16'h9805;
        mdl.mem[3] = 16'h0011;
        apb_xfer(1'b1, SECL_A_LCW, 32'h2000_0000);
        wait_load();
        rchk(SECL_A_IDENT, 32'h5678_12ee, '1);
        chk({nfunc[7:0], func_addr, func_data}, {8'd3, 8'h05, 8'h11});
    endtask : t_skip
    task automatic t_bitbang();
        apb_xfer(1'b1, SECL_A_LCW, 32'h0700_0000);
        @(negedge pclk);
        chk({ee_sk, ee_cs, ee_di}, 3'b111);
        rchk(SECL_A_LCW, {4'h0, ee_do, 27'h700_0000}, 32'h0f00_0000);
        apb_xfer(1'b1, SECL_A_LCW, 32'h0000_0000);
        @(negedge pclk);
        chk({ee_sk, ee_cs, ee_di}, 3'b000);
        apb_xfer(1'b0, 12'h800, '0);
        chk(err, 1);
    endtask : t_bitbang
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_absent();
        t_program();
        t_badsig();
        t_skip();
        t_bitbang();
        end_sim();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        end_sim();
    end
endmodule : secl_loader_tb
bind secl_loader secl_loader_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .ee_sk(ee_sk), .ee_cs(ee_cs), .ee_di(ee_di),
    .pci_retry(pci_retry), .func_valid(func_valid), .func_addr(func_addr));
